// [rtl/ect_pkg.sv]
// Package for the dedicated converter core timing and early interrupt block.
// Assumes a single 10 MHz clock and a simple strobe register port.
package ect_pkg;
    localparam int NCH = 26;
    localparam logic [25:0] CHAN_PRESENT = 26'h3FFFFFF;
    // Register offsets
    localparam logic [3:0] OFS_CORE0_DELAY = 4'h0;
    localparam logic [3:0] OFS_CORE0_TIMING = 4'h1;
    localparam logic [3:0] OFS_CORE1_DELAY = 4'h2;
    localparam logic [3:0] OFS_CORE1_TIMING = 4'h3;
    localparam logic [3:0] OFS_TRIG_LOW = 4'h4;
    localparam logic [3:0] OFS_TRIG_HIGH = 4'h5;
    localparam logic [3:0] OFS_EIE_LOW = 4'h6;
    localparam logic [3:0] OFS_EIE_HIGH = 4'h7;
    localparam logic [3:0] OFS_EIF_LOW = 4'h8;
    localparam logic [3:0] OFS_EIF_HIGH = 4'h9;
    localparam logic [3:0] OFS_COMMON = 4'hA;
    localparam logic [3:0] OFS_CHSEL = 4'hB;
    localparam logic [3:0] OFS_IRQ_STAT = 4'hC;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hD;
    localparam logic [3:0] OFS_CORE_STATE = 4'hE;
    // Field positions
    localparam int POS_LEAD = 10;
    localparam int POS_RES = 8;
    localparam int POS_DIV = 0;
    localparam int POS_DLY_EN = 8;
    localparam int POS_CH1 = 8;
    // Reset values
    localparam logic [15:0] RST_REG = 16'h0000;
    // Delay adds two core clocks, lead adds one
    localparam logic [10:0] DELAY_BASE = 11'h002;
    localparam logic [3:0] LEAD_BASE = 4'h1;
    // Conversion lengths in core clocks per resolution
    localparam logic [3:0] CONV_12 = 4'hE;
    localparam logic [3:0] CONV_10 = 4'hC;
    localparam logic [3:0] CONV_8 = 4'hA;
    localparam logic [3:0] CONV_6 = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } ect_state_t;

    typedef struct packed {
        logic delay_en;
        logic [9:0] delay;
        logic [2:0] lead;
        logic [1:0] res;
        logic [6:0] div;
    } ect_core_cfg_t;

    typedef struct packed {
        logic sampling;
        logic converting;
        logic early;
        logic ready;
        logic [4:0] chan;
    } ect_core_stat_t;

    // Core clocks for one conversion at a given resolution
    function automatic logic [3:0] ect_conv_len(input logic [1:0] res);
        case (res)
            2'b11: ect_conv_len = CONV_12;
            2'b10: ect_conv_len = CONV_10;
            2'b01: ect_conv_len = CONV_8;
            default: ect_conv_len = CONV_6;
        endcase
    endfunction : ect_conv_len

    // High half of a channel field, bits 15-10 read zero
    function automatic logic [15:0] ect_hi(input logic [25:0] v);
        ect_hi = {6'h00, v[25:16]};
    endfunction : ect_hi
endpackage : ect_pkg

// [rtl/ect_common_source_divider.sv]
// Enable divider: one output pulse every limit+1 input enables.
// Assumes en_in is a one-cycle pulse in the mclk domain.
`timescale 1ns/100ps
module ect_common_source_divider import ect_pkg::*; #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Divider control
    input wire logic en_in,
    input wire logic [W-1:0] limit,
    // Divided enable
    output logic pulse
);
    logic [W-1:0] cnt_r;

    // Count input enables; a lowered limit wraps at once, no long stall
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (en_in) begin
            if (cnt_r >= limit) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign pulse = en_in && (cnt_r >= limit);
endmodule : ect_common_source_divider

// [rtl/ect_core.sv]
// Timing sequencer for one dedicated converter core.
// Assumes core_en is a one-cycle pulse per core clock period.
`timescale 1ns/100ps
module ect_core import ect_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Configuration and pacing
    input wire ect_core_cfg_t cfg,
    input wire logic core_en,
    // Trigger from the selected channel
    input wire logic trig,
    input wire logic [4:0] trig_chan,
    // Status
    output ect_core_stat_t stat
);
    ect_state_t state_r;
    logic [10:0] cnt_r;
    logic [4:0] chan_r;
    logic early_r;
    logic ready_r;
    logic [3:0] len;
    logic [3:0] lead_eff;

    // Lead counted back from the ready clock; a lead that reaches the
    // conversion length fires on its first clock, so bad codes still pulse
    assign len = ect_conv_len(cfg.res);
    assign lead_eff = ({1'b0, cfg.lead} + LEAD_BASE >= len) ? len - 4'h1 :
        {1'b0, cfg.lead} + LEAD_BASE;

    // Sequencer; a trigger while converting is ignored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            chan_r <= '0;
        end else if (trig && state_r != ST_CONVERT) begin
            chan_r <= trig_chan;
            if (cfg.delay_en) begin
                state_r <= ST_SAMPLE;
                cnt_r <= {1'b0, cfg.delay} + DELAY_BASE;
            end else begin
                state_r <= ST_CONVERT;
                cnt_r <= {7'h00, len};
            end
        end else if (core_en) begin
            case (state_r)
                ST_SAMPLE: begin
                    if (cnt_r == 11'h001) begin
                        state_r <= ST_CONVERT;
                        cnt_r <= {7'h00, len};
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_CONVERT: begin
                    if (cnt_r == 11'h001) begin
                        state_r <= ST_IDLE;
                    end
                    cnt_r <= cnt_r - 1'b1;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Early and ready pulses, registered
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            early_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            // Ready follows the clock at count one, so one more for the lead
            early_r <= core_en && state_r == ST_CONVERT &&
                cnt_r == {7'h00, lead_eff} + 11'h001;
            ready_r <= core_en && state_r == ST_CONVERT && cnt_r == 11'h001;
        end
    end

    assign stat.sampling = (state_r == ST_SAMPLE);
    assign stat.converting = (state_r == ST_CONVERT);
    assign stat.early = early_r;
    assign stat.ready = ready_r;
    assign stat.chan = chan_r;
endmodule : ect_core

// [rtl/ect_top.sv]
// Top of the converter core timing block: registers, trigger sensing,
// dividers, two core sequencers, early flags and the interrupt.
// Assumes inputs synchronous to mclk and a one-cycle strobe register port.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module ect_top import ect_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Channel triggers
    input wire logic [25:0] trig_in,
    // Result buffer read notice
    input wire logic res_rd,
    input wire logic [4:0] res_rd_chan,
    // Core status and interrupt
    output ect_core_stat_t [1:0] core_stat,
    output logic irq
);
    // Configuration registers
    logic [9:0] delay_r [2];
    logic [2:0] lead_r [2];
    logic [1:0] res_r [2];
    logic [6:0] div_r [2];
    logic [1:0] dly_en_r;
    logic [5:0] cdiv_r;
    logic [4:0] chsel_r [2];
    logic [25:0] lvl_r;
    logic [25:0] eie_r;
    logic [25:0] eif_r;
    logic [3:0] ists_r;
    logic [3:0] imask_r;
    logic [25:0] trig_prev_r;
    logic [15:0] rdata_nxt;

    // Working signals
    logic src_en;
    logic [1:0] core_en;
    logic [25:0] trig_evt;
    logic [25:0] eif_set;
    logic [25:0] eif_clr;
    logic [3:0] ists_set;
    logic [1:0] core_trig;
    ect_core_cfg_t [1:0] cfg;
    ect_core_stat_t [1:0] stat;

    // Divider limit giving twice the code in source periods, code zero taken as one
    function automatic logic [7:0] core_limit(input logic [6:0] div);
        logic [6:0] d;
        d = (div == 7'h00) ? 7'h01 : div;
        core_limit = {d, 1'b0} - 8'h01;
    endfunction : core_limit

    // One-hot of a channel number, zero for absent channels
    function automatic logic [25:0] chan_hot(input logic [4:0] ch);
        logic [25:0] h;
        h = '0;
        if (ch < 5'd26) begin
            h[ch] = 1'b1;
        end
        chan_hot = h & CHAN_PRESENT;
    endfunction : chan_hot

    // Per-core configuration registers, independent copies
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                delay_r[i] <= RST_REG[9:0];
                lead_r[i] <= RST_REG[2:0];
                res_r[i] <= RST_REG[1:0];
                div_r[i] <= RST_REG[6:0];
            end
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_CORE0_DELAY: delay_r[0] <= reg_wdata[9:0];
                OFS_CORE1_DELAY: delay_r[1] <= reg_wdata[9:0];
                OFS_CORE0_TIMING: begin
                    lead_r[0] <= reg_wdata[POS_LEAD+:3];
                    res_r[0] <= reg_wdata[POS_RES+:2];
                    div_r[0] <= reg_wdata[POS_DIV+:7];
                end
                OFS_CORE1_TIMING: begin
                    lead_r[1] <= reg_wdata[POS_LEAD+:3];
                    res_r[1] <= reg_wdata[POS_RES+:2];
                    div_r[1] <= reg_wdata[POS_DIV+:7];
                end
                default: ;
            endcase
        end
    end

    // Common divider, delay enables and channel selection
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cdiv_r <= RST_REG[5:0];
            dly_en_r <= RST_REG[1:0];
            chsel_r[0] <= RST_REG[4:0];
            chsel_r[1] <= RST_REG[4:0];
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_COMMON: begin
                    cdiv_r <= reg_wdata[5:0];
                    dly_en_r <= reg_wdata[POS_DLY_EN+:2];
                end
                OFS_CHSEL: begin
                    chsel_r[0] <= reg_wdata[4:0];
                    chsel_r[1] <= reg_wdata[POS_CH1+:5];
                end
                default: ;
            endcase
        end
    end

    // Channel trigger sense and early enables, absent bits stay zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lvl_r <= '0;
            eie_r <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_TRIG_LOW: lvl_r[15:0] <= reg_wdata & CHAN_PRESENT[15:0];
                OFS_TRIG_HIGH:
                    lvl_r[25:16] <= reg_wdata[9:0] & CHAN_PRESENT[25:16];
                OFS_EIE_LOW: eie_r[15:0] <= reg_wdata & CHAN_PRESENT[15:0];
                OFS_EIE_HIGH:
                    eie_r[25:16] <= reg_wdata[9:0] & CHAN_PRESENT[25:16];
                default: ;
            endcase
        end
    end

    // Previous trigger levels for edge detection
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trig_prev_r <= '0;
        end else begin
            trig_prev_r <= trig_in;
        end
    end

    // Level mode retriggers while high; edge mode needs a rising edge
    assign trig_evt = CHAN_PRESENT & ((lvl_r & trig_in) |
        (~lvl_r & trig_in & ~trig_prev_r));

    // Common source clock enable, divide by code plus one
    ect_common_source_divider #(.W(6)) u_srcdiv (
        .mclk(mclk),
        .rst(rst),
        .en_in(1'b1),
        .limit(cdiv_r),
        .pulse(src_en)
    );

    // Per-core dividers, configuration and sequencers
    for (genvar c = 0; c < 2; c++) begin : g_core
        ect_common_source_divider #(.W(8)) u_corediv (
            .mclk(mclk),
            .rst(rst),
            .en_in(src_en),
            .limit(core_limit(div_r[c])),
            .pulse(core_en[c])
        );

        assign cfg[c].delay_en = dly_en_r[c];
        assign cfg[c].delay = delay_r[c];
        assign cfg[c].lead = lead_r[c];
        assign cfg[c].res = res_r[c];
        assign cfg[c].div = div_r[c];
        assign core_trig[c] = |(trig_evt & chan_hot(chsel_r[c]));

        ect_core u_core (
            .mclk(mclk),
            .rst(rst),
            .cfg(cfg[c]),
            .core_en(core_en[c]),
            .trig(core_trig[c]),
            .trig_chan(chsel_r[c]),
            .stat(stat[c])
        );
    end

    assign core_stat = stat;

    // Early flag set and clear terms; an out-of-range lead is clamped in the core
    assign eif_set = ({26{stat[0].early}} & chan_hot(stat[0].chan) |
        {26{stat[1].early}} & chan_hot(stat[1].chan)) & eie_r;
    assign eif_clr = {26{res_rd}} & chan_hot(res_rd_chan);

    // Early flags: a result read clears, a coincident set wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            eif_r <= '0;
        end else begin
            eif_r <= (eif_r & ~eif_clr) | eif_set;
        end
    end

    // Interrupt events: early per core (when enabled), ready per core
    assign ists_set = {stat[1].ready, stat[0].ready,
        |(eif_set & chan_hot(stat[1].chan)),
        |(eif_set & chan_hot(stat[0].chan))};

    // Sticky status, write one to clear, set wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ists_r <= '0;
        end else if (reg_wr && reg_addr == OFS_IRQ_STAT) begin
            ists_r <= (ists_r & ~reg_wdata[3:0]) | ists_set;
        end else begin
            ists_r <= ists_r | ists_set;
        end
    end

    // Interrupt mask
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            imask_r <= '0;
        end else if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
            imask_r <= reg_wdata[3:0];
        end
    end

    // Level interrupt, gated by the mask
    assign irq = |(ists_r & imask_r);

    // Read data selection; unmapped offsets read zero
    always_comb begin
        rdata_nxt = RST_REG;
        case (reg_addr)
            OFS_CORE0_DELAY: rdata_nxt = {6'h00, delay_r[0]};
            OFS_CORE1_DELAY: rdata_nxt = {6'h00, delay_r[1]};
            OFS_CORE0_TIMING:
                rdata_nxt = {3'h0, lead_r[0], res_r[0], 1'b0, div_r[0]};
            OFS_CORE1_TIMING:
                rdata_nxt = {3'h0, lead_r[1], res_r[1], 1'b0, div_r[1]};
            OFS_TRIG_LOW: rdata_nxt = lvl_r[15:0];
            OFS_TRIG_HIGH: rdata_nxt = ect_hi(lvl_r);
            OFS_EIE_LOW: rdata_nxt = eie_r[15:0];
            OFS_EIE_HIGH: rdata_nxt = ect_hi(eie_r);
            OFS_EIF_LOW: rdata_nxt = eif_r[15:0];
            OFS_EIF_HIGH: rdata_nxt = ect_hi(eif_r);
            OFS_COMMON: rdata_nxt = {6'h00, dly_en_r, 2'h0, cdiv_r};
            OFS_CHSEL: rdata_nxt = {3'h0, chsel_r[1], 3'h0, chsel_r[0]};
            OFS_IRQ_STAT: rdata_nxt = {12'h000, ists_r};
            OFS_IRQ_MASK: rdata_nxt = {12'h000, imask_r};
            OFS_CORE_STATE: rdata_nxt = {12'h000, stat[1].converting,
                stat[1].sampling, stat[0].converting, stat[0].sampling};
            default: rdata_nxt = RST_REG;
        endcase
    end

    // Read data register, valid the cycle after the strobe only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= RST_REG;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= RST_REG;
        end
    end
endmodule : ect_top

// [tb/ect_assertions.sv]
// Checker for the converter core timing block, bound to its top module.
// Assumes it sees only the top ports, all in the single mclk domain.
`timescale 1ns/100ps
module ect_assertions import ect_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Triggers and result reads
    input wire logic [25:0] trig_in,
    input wire logic res_rd,
    input wire logic [4:0] res_rd_chan,
    // Core status and interrupt
    input wire ect_core_stat_t [1:0] core_stat,
    input wire logic irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Anything that may raise the interrupt one cycle later
    logic irq_cause;
    assign irq_cause = core_stat[0].early || core_stat[0].ready ||
        core_stat[1].early || core_stat[1].ready || reg_wr;

    // Read data stand only in the cycle after a read
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("Read data not idle");
    unmapped_rd_a: assert property (
        reg_rd && reg_addr == 4'hF |=> reg_rdata == 16'h0000)
        else $error("Unmapped read not zero");
    hi_bits_zero_a: assert property (
        reg_rd && reg_addr inside {4'h5, 4'h7, 4'h9}
        |=> reg_rdata[15:10] == 6'h00)
        else $error("High register top bits not zero");
    irq_cause_a: assert property (
        $rose(irq) |-> $past(irq_cause))
        else $error("Interrupt rose without a cause");

    // Per-core sequencing, same checks for both cores
    for (genvar c = 0; c < 2; c++) begin : g_core
        samp_conv_excl_a: assert property (
            !(core_stat[c].sampling && core_stat[c].converting))
            else $error("Sampling and converting together");
        samp_to_conv_a: assert property (
            $fell(core_stat[c].sampling) |-> core_stat[c].converting)
            else $error("Sampling ended without conversion");
        ready_end_a: assert property (
            core_stat[c].ready
            |-> !core_stat[c].converting && $past(core_stat[c].converting))
            else $error("Ready outside end of conversion");
        conv_fall_a: assert property (
            $fell(core_stat[c].converting) |-> core_stat[c].ready)
            else $error("Conversion ended without ready");
        early_in_conv_a: assert property (
            core_stat[c].early |-> core_stat[c].converting)
            else $error("Early pulse outside conversion");
        ready_single_a: assert property (
            core_stat[c].ready |=> !core_stat[c].ready [*8])
            else $error("Ready pulses too close");
        chan_hold_a: assert property (
            core_stat[c].converting && $past(core_stat[c].converting)
            |-> $stable(core_stat[c].chan))
            else $error("Channel changed in conversion");
    end
endmodule : ect_assertions

bind ect_top ect_assertions ect_assertions_i (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trig_in(trig_in), .res_rd(res_rd), .res_rd_chan(res_rd_chan),
    .core_stat(core_stat), .irq(irq)
);

// [tb/ect_top_tb.sv]
// Self-checking bench for the converter core timing block top.
// Assumes the package register map, a 10 MHz clock and async reset.
`timescale 1ns/100ps
module ect_top_tb import ect_pkg::*; ;
    // Design ports
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [25:0] trig_in = 26'h0000000;
    logic res_rd = 1'b0;
    logic [4:0] res_rd_chan = 5'h00;
    ect_core_stat_t [1:0] core_stat;
    logic irq;
    // Bookkeeping
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    ect_top ect_top_i (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trig_in(trig_in), .res_rd(res_rd), .res_rd_chan(res_rd_chan),
        .core_stat(core_stat), .irq(irq)
    );

    // 100 ns clock
    initial begin
        forever #50 mclk = ~mclk;
    end

    // Hang guard, well above the longest expected run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Phase of the core clock is unknown, so allow one period of slack
    task automatic win(input string what, input int v, input int n,
        input int p);
        check(what, 32'(v > (n - 1) * p && v <= n * p), 32'h1);
    endtask : win

    // Write, then a quiet cycle so a strobe is never assigned twice
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    // Read, taking the data in the one cycle where they stand
    task automatic rdchk(input string what, input logic [3:0] a,
        input logic [15:0] exp);
        logic [15:0] d;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
        @(posedge mclk);
        check(what, {16'h0000, d}, {16'h0000, exp});
    endtask : rdchk

    // Trigger a channel, count sampling and converting cycles and the
    // distance from the early pulse to ready
    task automatic run(input int c, input int ch, output int ns,
        output int nc, output int gap);
        int n;
        int e;
        ns = 0;
        nc = 0;
        e = -1;
        trig_in[ch] <= 1'b1;
        for (n = 0; n < 40000; n++) begin
            @(negedge mclk);
            if (core_stat[c].sampling === 1'b1) ns++;
            if (core_stat[c].converting === 1'b1) nc++;
            if (core_stat[c].early === 1'b1) e = n;
            if (core_stat[c].ready === 1'b1) break;
        end
        gap = n - e;
        check("core channel", {27'h0, core_stat[c].chan}, 32'(ch));
        @(posedge mclk);
        trig_in[ch] <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : run

    task automatic t_regs();
        for (int a = 0; a < 16; a++) begin
            rdchk("reset value", 4'(a), 16'h0000);
        end
        wr(OFS_CORE0_DELAY, 16'hFFFF);
        rdchk("delay field", OFS_CORE0_DELAY, 16'h03FF);
        wr(OFS_CORE0_TIMING, 16'hFFFF);
        rdchk("timing fields", OFS_CORE0_TIMING, 16'h1F7F);
        rdchk("core1 timing", OFS_CORE1_TIMING, 16'h0000);
        wr(OFS_TRIG_LOW, 16'hFFFF);
        rdchk("trigger low", OFS_TRIG_LOW, 16'hFFFF);
        wr(OFS_EIE_HIGH, 16'hFFFF);
        rdchk("enable high", OFS_EIE_HIGH, 16'h03FF);
        wr(OFS_EIF_LOW, 16'hFFFF);
        rdchk("flags written", OFS_EIF_LOW, 16'h0000);
        wr(4'hF, 16'hFFFF);
        rdchk("unmapped", 4'hF, 16'h0000);
        wr(OFS_TRIG_LOW, 16'h0000);
        wr(OFS_EIE_HIGH, 16'h0000);
        wr(OFS_CORE0_DELAY, 16'h0000);
        wr(OFS_CHSEL, 16'h1403);
    endtask : t_regs

    task automatic t_div();
        logic [6:0] dv [5] = '{7'h00, 7'h01, 7'h03, 7'h7F, 7'h01};
        logic [5:0] cd [5] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h3F};
        int pp [5] = '{2, 2, 6, 254, 128};
        int ns, nc, gp;
        for (int i = 0; i < 5; i++) begin
            wr(OFS_COMMON, {10'h000, cd[i]});
            wr(OFS_CORE0_TIMING, {9'h000, dv[i]});
            run(0, 3, ns, nc, gp);
            check("core period", 32'(gp), 32'(pp[i]));
            win("6-bit length", nc, 8, pp[i]);
        end
        wr(OFS_COMMON, 16'h0000);
    endtask : t_div

    task automatic t_len();
        int ln [4] = '{8, 10, 12, 14};
        int ns, nc, gp;
        for (int r = 0; r < 4; r++) begin
            wr(OFS_CORE0_TIMING, {6'h00, 2'(r), 8'h01});
            run(0, 3, ns, nc, gp);
            win("conversion length", nc, ln[r], 2);
        end
        // Core 0 left on a slow divider while core 1 runs fast
        wr(OFS_CORE0_TIMING, 16'h007F);
        for (int l = 0; l < 8; l++) begin
            wr(OFS_CORE1_TIMING, {3'h0, 3'(l), 2'b11, 8'h01});
            run(1, 20, ns, nc, gp);
            check("early lead", 32'(gp), 32'(2 * (l + 1)));
        end
    endtask : t_len

    task automatic t_delay();
        logic [9:0] dl [3] = '{10'h000, 10'h005, 10'h3FF};
        int ns, nc, gp;
        wr(OFS_CORE0_TIMING, 16'h0001);
        wr(OFS_COMMON, 16'h0100);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CORE0_DELAY, {6'h00, dl[i]});
            run(0, 3, ns, nc, gp);
            win("delay length", ns, int'(dl[i]) + 2, 2);
            win("length after delay", nc, 8, 2);
        end
        // Only core 1 delayed: core 0 must ignore its count
        wr(OFS_COMMON, 16'h0200);
        run(0, 3, ns, nc, gp);
        check("no delay sampling", 32'(ns), 32'd0);
        win("immediate conversion", nc, 8, 2);
        wr(OFS_COMMON, 16'h0000);
    endtask : t_delay

    task automatic t_trig();
        int k;
        for (int lvl = 0; lvl < 2; lvl++) begin
            wr(OFS_TRIG_HIGH, lvl == 1 ? 16'h0010 : 16'h0000);
            k = 0;
            trig_in[20] <= 1'b1;
            repeat (200) begin
                @(negedge mclk);
                if (core_stat[1].ready === 1'b1) k++;
            end
            @(posedge mclk);
            trig_in[20] <= 1'b0;
            repeat (40) @(posedge mclk);
            check("retrigger", 32'(k > 1), 32'(lvl));
        end
        wr(OFS_TRIG_HIGH, 16'h0000);
    endtask : t_trig

    task automatic t_flags();
        int ns, nc, gp;
        wr(OFS_IRQ_STAT, 16'h000F);
        wr(OFS_EIE_LOW, 16'h0008);
        wr(OFS_IRQ_MASK, 16'h0001);
        run(0, 3, ns, nc, gp);
        rdchk("flag set", OFS_EIF_LOW, 16'h0008);
        check("irq raised", {31'h0, irq}, 32'h1);
        wr(OFS_IRQ_STAT, 16'h000F);
        check("irq cleared", {31'h0, irq}, 32'h0);
        res_rd_chan <= 5'd3;
        res_rd <= 1'b1;
        @(posedge mclk);
        res_rd <= 1'b0;
        @(posedge mclk);
        rdchk("flag cleared", OFS_EIF_LOW, 16'h0000);
        wr(OFS_EIE_LOW, 16'h0000);
        run(0, 3, ns, nc, gp);
        rdchk("flag gated", OFS_EIF_LOW, 16'h0000);
        rdchk("ready status", OFS_IRQ_STAT, 16'h0004);
        check("irq masked", {31'h0, irq}, 32'h0);
    endtask : t_flags

    // Main sequence after a five-cycle reset
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_div();
        t_len();
        t_delay();
        t_trig();
        t_flags();
        close_out();
    end
endmodule : ect_top_tb
